// File: rtl/cocr_regs.sv
// serial write port and output clocking configuration registers
`timescale 1ns/100ps
// Overview of operation
// - The bank holds write-only control registers whose contents act only in extended mode.
// - In normal mode the register values are ignored; the pins steer swing and launch edge, the other outputs are fixed.
// - Reset loads 0xB2FF into the clocking configuration and 0x007F into the offset register.
// - Configuration bit 12 turns on duty-cycle stabilisation of the sample clock.
// - Configuration bit 11 sets the double-rate clock phase and matters only in double rate.
// - Configuration bit 10 at 0 gives double rate, at 1 single rate on the chosen edge.
// - Configuration bit 9 picks the output swing, 1 standard and 0 reduced.
// - Configuration bit 8 picks the single-rate launch edge, 1 rising and 0 falling.
// - Offset bits 15:8 hold the magnitude and bit 7 the sign, negative when set.
// - Serial bits are taken on the rising serial clock edge with no minimum rate.
// - Each access is 32 bits, MSB first: 12-bit header, 4-bit address, 16 data bits.
// - Address 1h writes the configuration register and 2h the offset register.
module cocr_regs
  import cocr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic ext_mode_i,
  input wire logic serial_clk_i,
  input wire logic serial_shift_in_i,
  input wire logic serial_select_n_i,
  input wire logic launch_edge_pin_i,
  input wire logic swing_select_pin_i,
  output logic duty_fix_enable_o,
  output logic double_rate_edge_phase_o,
  output logic single_rate_select_o,
  output logic output_swing_select_o,
  output logic launch_edge_o,
  output logic [7:0] offset_magnitude_o,
  output logic offset_negative_o,
  output logic write_done_o
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic sclk_s;
  logic serial_shift_in_s;
  logic sel_n_s;
  logic ext_s;
  logic edge_pin_s;
  logic swing_pin_s;

  cocr_sync2 #(.RST_VAL(1'b0)) u_sync_sclk (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(serial_clk_i), .sync_o(sclk_s));
  cocr_sync2 #(.RST_VAL(1'b0)) u_sync_serial_shift_in (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(serial_shift_in_i), .sync_o(serial_shift_in_s));
  cocr_sync2 #(.RST_VAL(1'b1)) u_sync_sel (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(serial_select_n_i), .sync_o(sel_n_s));
  cocr_sync2 #(.RST_VAL(1'b0)) u_sync_ext (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(ext_mode_i), .sync_o(ext_s));
  cocr_sync2 #(.RST_VAL(1'b0)) u_sync_edge (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(launch_edge_pin_i), .sync_o(edge_pin_s));
  cocr_sync2 #(.RST_VAL(1'b1)) u_sync_swing (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .async_i(swing_select_pin_i), .sync_o(swing_pin_s));

  // ----------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------
  logic sclk_d_ff;
  logic [30:0] shift_ff;
  logic [30:0] nxt_shift;
  logic [4:0] count_ff;
  logic [4:0] nxt_count;
  logic [15:0] cfg_ff;
  logic [15:0] nxt_cfg;
  logic [15:0] ofs_ff;
  logic [15:0] nxt_ofs;
  logic done_ff;
  logic nxt_done;
  logic sclk_rise;
  logic [31:0] frame;
  // count value while the last bit of a frame is being taken
  localparam logic [4:0] LAST_BIT = 5'(FRAME_BITS - 1);

  // the incoming bit is appended combinationally so the 32nd bit needs no extra stage
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign frame = {shift_ff, serial_shift_in_s};

  // layout guard: the 5-bit counter and 31-bit shifter serve a 32-bit frame only
  if (FRAME_BITS != 32 || HDR_BITS + ADDR_BITS + DATA_BITS != FRAME_BITS) begin : g_bad_layout
    $error("frame layout does not fit the shifter");
  end

  // shift and count on each rising serial edge, commit on the 32nd
  always_comb begin
    nxt_shift = shift_ff;
    nxt_count = count_ff;
    nxt_cfg = cfg_ff;
    nxt_ofs = ofs_ff;
    nxt_done = 1'b0;
    if (sel_n_s || !ext_s) begin
      // deselect or normal mode aborts any partial frame
      nxt_count = 5'h00;
    end else if (sclk_rise) begin
      nxt_shift = frame[30:0];
      nxt_count = count_ff + 5'h01;
      if (count_ff == LAST_BIT && frame[31:20] == FRAME_HEADER) begin
        nxt_done = 1'b1;
        if (frame[19:16] == ADDR_OUTPUT_CLOCKING_CONFIG) begin
          nxt_cfg = frame[15:0];
        end else if (frame[19:16] == ADDR_FIRST_CHANNEL_OFFSET) begin
          nxt_ofs = frame[15:0];
        end
      end
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_d_ff <= 1'b0;
      shift_ff <= 31'h0;
      count_ff <= 5'h00;
      cfg_ff <= RST_OUTPUT_CLOCKING_CONFIG;
      ofs_ff <= RST_FIRST_CHANNEL_OFFSET;
      done_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
      shift_ff <= nxt_shift;
      count_ff <= nxt_count;
      cfg_ff <= nxt_cfg;
      ofs_ff <= nxt_ofs;
      done_ff <= nxt_done;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // bit 4 stabiliser, 3 phase, 2 rate, 1 swing, 0 launch edge
  logic [4:0] out_ff;
  logic [4:0] nxt_out;

  // normal mode uses pins; pins give double rate, stabiliser on, zero offset
  always_comb begin
    nxt_out = {1'b1, 1'b0, 1'b0, swing_pin_s, edge_pin_s};
    if (ext_s) begin
      nxt_out[4] = cfg_ff[POS_DUTY_FIX_ENABLE]; // stabiliser
      nxt_out[3] = cfg_ff[POS_DOUBLE_RATE_EDGE_PHASE]; // phase
      nxt_out[2] = cfg_ff[POS_SINGLE_RATE_SELECT]; // rate
      nxt_out[1] = cfg_ff[POS_OUTPUT_SWING_SELECT]; // swing
      nxt_out[0] = cfg_ff[POS_LAUNCH_EDGE]; // launch edge
    end
  end

  logic [7:0] mag_ff;
  logic sign_ff;
  logic [7:0] nxt_mag;
  logic nxt_sign;

  // offset fields, zero in normal mode
  always_comb begin
    nxt_mag = 8'h00;
    nxt_sign = 1'b0;
    if (ext_s) begin
      nxt_mag = ofs_ff[POS_OFFSET_MAG_HI:POS_OFFSET_MAG_LO];
      nxt_sign = ofs_ff[POS_OFFSET_SIGN];
    end
  end

  // output registers
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // reset shows the register defaults, so extended mode starts clean
      out_ff <= RST_OUTPUT_CLOCKING_CONFIG[POS_DUTY_FIX_ENABLE:POS_LAUNCH_EDGE];
      mag_ff <= 8'h00;
      sign_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
      mag_ff <= nxt_mag;
      sign_ff <= nxt_sign;
    end
  end

  assign duty_fix_enable_o = out_ff[4];
  assign double_rate_edge_phase_o = out_ff[3];
  assign single_rate_select_o = out_ff[2];
  assign output_swing_select_o = out_ff[1];
  assign launch_edge_o = out_ff[0];
  assign offset_magnitude_o = mag_ff;
  assign offset_negative_o = sign_ff;
  assign write_done_o = done_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_cfg_reset: assert property (@(posedge mclk_i)
    $rose(resetn_i) |-> cfg_ff == RST_OUTPUT_CLOCKING_CONFIG && ofs_ff == RST_FIRST_CHANNEL_OFFSET)
    else $error("reset defaults wrong");
  chk_normal_pins: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !ext_s |=> output_swing_select_o == $past(swing_pin_s) && offset_magnitude_o == 8'h00)
    else $error("normal mode ignores pins");
  chk_ext_stab: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> duty_fix_enable_o == $past(cfg_ff[POS_DUTY_FIX_ENABLE]))
    else $error("stabiliser not from register");
  chk_ext_phase: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> double_rate_edge_phase_o == $past(cfg_ff[POS_DOUBLE_RATE_EDGE_PHASE]))
    else $error("phase not from register");
  chk_ext_rate: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> single_rate_select_o == $past(cfg_ff[POS_SINGLE_RATE_SELECT]))
    else $error("rate not from register");
  chk_ext_swing: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> output_swing_select_o == $past(cfg_ff[POS_OUTPUT_SWING_SELECT]))
    else $error("swing not from register");
  chk_ext_edge: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> launch_edge_o == $past(cfg_ff[POS_LAUNCH_EDGE]))
    else $error("edge not from register");
  chk_ext_offset: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> offset_negative_o == $past(ofs_ff[POS_OFFSET_SIGN]))
    else $error("offset sign not from register");
  chk_frame_commit: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    write_done_o |-> $past(count_ff) == 5'h1F)
    else $error("commit before 32 bits");
  chk_idle_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !write_done_o |-> $stable(cfg_ff) && $stable(ofs_ff))
    else $error("register changed without a frame");

  // ----------------------------------------------------------------
  // frame sequences and their checks
  // ----------------------------------------------------------------
  // a rising serial edge that takes a bit of a live frame
  sequence seq_bit_taken;
    !sel_n_s && ext_s && sclk_rise;
  endsequence

  // the 32nd bit of a frame whose header is good
  sequence seq_good_frame;
    seq_bit_taken ##0 (count_ff == LAST_BIT && frame[31:20] == FRAME_HEADER);
  endsequence

  // the 32nd bit of a frame whose header is wrong
  sequence seq_bad_frame;
    seq_bit_taken ##0 (count_ff == LAST_BIT && frame[31:20] != FRAME_HEADER);
  endsequence

  // every taken bit advances the count, wrapping after the 32nd
  chk_bit_count: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    seq_bit_taken |=> count_ff == $past(count_ff) + 5'h01)
    else $error("bit count did not advance");

  // the shifter only moves on a rising serial edge
  chk_shift_hold: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !sclk_rise |=> $stable(shift_ff))
    else $error("shifter moved without a serial edge");

  // deselect or normal mode drops a partial frame
  chk_abort_clear: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    (sel_n_s || !ext_s) |=> count_ff == 5'h00)
    else $error("partial frame survived deselect");

  // a good frame gives exactly one completion pulse
  chk_done_pulse: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    seq_good_frame |=> write_done_o ##1 !write_done_o)
    else $error("completion pulse missing or stretched");

  // a bad header leaves both registers alone
  chk_bad_header: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    seq_bad_frame |=> !write_done_o && $stable(cfg_ff) && $stable(ofs_ff))
    else $error("frame with a bad header landed");

  // address 1h loads the data field into the configuration register
  chk_cfg_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    seq_good_frame ##0 (frame[19:16] == ADDR_OUTPUT_CLOCKING_CONFIG)
    |=> cfg_ff == $past(frame[15:0]))
    else $error("configuration write lost");

  // address 2h loads the data field into the offset register
  chk_ofs_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    seq_good_frame ##0 (frame[19:16] == ADDR_FIRST_CHANNEL_OFFSET)
    |=> ofs_ff == $past(frame[15:0]))
    else $error("offset write lost");

  // extended mode shows the stored magnitude
  chk_ext_magnitude: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    ext_s |=> offset_magnitude_o == $past(ofs_ff[POS_OFFSET_MAG_HI:POS_OFFSET_MAG_LO]))
    else $error("offset magnitude not from register");

  // normal mode shows the fixed pin defaults
  chk_normal_fixed: assert property (@(posedge mclk_i) disable iff (!resetn_i)
    !ext_s |=> duty_fix_enable_o && !double_rate_edge_phase_o && !single_rate_select_o
    && launch_edge_o == $past(edge_pin_s) && !offset_negative_o)
    else $error("normal mode defaults wrong");

  // outputs still show the register defaults at the release of reset
  chk_reset_outputs: assert property (@(posedge mclk_i)
    $rose(resetn_i) |-> duty_fix_enable_o && output_swing_select_o && !launch_edge_o
    && !double_rate_edge_phase_o && !single_rate_select_o && offset_magnitude_o == 8'h00)
    else $error("reset outputs wrong");
endmodule // cocr_regs

// File: pkg/cocr_pkg.sv
// constants for the converter output configuration register bank
package cocr_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 32;
  localparam int HDR_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 16;
  localparam logic [11:0] FRAME_HEADER = 12'h001;
  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_OUTPUT_CLOCKING_CONFIG = 4'h1;
  localparam logic [3:0] ADDR_FIRST_CHANNEL_OFFSET = 4'h2;
  localparam logic [15:0] RST_OUTPUT_CLOCKING_CONFIG = 16'hB2FF;
  localparam logic [15:0] RST_FIRST_CHANNEL_OFFSET = 16'h007F;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_DUTY_FIX_ENABLE = 12;
  localparam int POS_DOUBLE_RATE_EDGE_PHASE = 11;
  localparam int POS_SINGLE_RATE_SELECT = 10;
  localparam int POS_OUTPUT_SWING_SELECT = 9;
  localparam int POS_LAUNCH_EDGE = 8;
  localparam int POS_OFFSET_MAG_HI = 15;
  localparam int POS_OFFSET_MAG_LO = 8;
  localparam int POS_OFFSET_SIGN = 7;
endpackage : cocr_pkg

// File: rtl/cocr_sync2.sv
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/100ps
module cocr_sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  logic sync_ff;

  // first stage feeds only the second
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule // cocr_sync2

// File: test/cocr_host_model.sv
// host side model of the three-wire serial write port
`timescale 1ns/100ps
module cocr_host_model (
  input wire logic mclk_i,
  output logic serial_clk_o,
  output logic serial_shift_in_o,
  output logic serial_select_n_o
);
  // idle: clock parked low, select high
  initial begin
    serial_clk_o = 1'b0;
    serial_shift_in_o = 1'b1;
    serial_select_n_o = 1'b1;
  end
  // select low throughout, msb first, rise mid-bit
  task automatic send(input logic [31:0] f, input int n, input bit keep);
    for (int i = 31; i > 31 - n; i--) begin
      repeat (4) @(posedge mclk_i);
      #10;
      serial_select_n_o = 1'b0;
      serial_clk_o = 1'b0;
      serial_shift_in_o = f[i];
      repeat (4) @(posedge mclk_i);
      #10;
      serial_clk_o = 1'b1;
    end
    repeat (4) @(posedge mclk_i);
    #10;
    serial_clk_o = 1'b0;
    // released data shows the inverse, never a stale valid bit
    serial_shift_in_o = ~serial_shift_in_o;
    serial_select_n_o = !keep;
  endtask
endmodule // cocr_host_model

// File: test/tb.sv
// self-checking bench for the output clocking configuration registers
`timescale 1ns/100ps
module tb;
  import cocr_pkg::*;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ext_mode_i = 1'b1;
  logic le_pin = 1'b0;
  logic sw_pin = 1'b0;
  logic sclk, sdi, sel_n, duty, phase, single, swing, edge_o, neg, done;
  logic [7:0] mag;
  logic [15:0] cfg_m = RST_OUTPUT_CLOCKING_CONFIG;
  logic [15:0] ofs_m = RST_FIRST_CHANNEL_OFFSET;
  int n_errors = 0;
  int n_compared = 0;
  int n_done = 0;
  int n_exp = 0;
  logic [3:0] bad_addr [4] = '{4'h0, 4'h3, 4'hD, 4'hA};
  always #50 mclk_i = ~mclk_i;
  cocr_host_model i_host (.mclk_i(mclk_i), .serial_clk_o(sclk), .serial_shift_in_o(sdi),
    .serial_select_n_o(sel_n));
  cocr_regs i_dut (.mclk_i(mclk_i), .resetn_i(resetn_i), .ext_mode_i(ext_mode_i),
    .serial_clk_i(sclk), .serial_shift_in_i(sdi), .serial_select_n_i(sel_n),
    .launch_edge_pin_i(le_pin), .swing_select_pin_i(sw_pin), .duty_fix_enable_o(duty),
    .double_rate_edge_phase_o(phase), .single_rate_select_o(single),
    .output_swing_select_o(swing), .launch_edge_o(edge_o), .offset_magnitude_o(mag),
    .offset_negative_o(neg), .write_done_o(done));
  // count completion pulses; a stretched pulse counts twice
  always @(posedge mclk_i) begin
    if (done === 1'b1) n_done++;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // expected outputs: registers in extended mode, pins and defaults otherwise
  function automatic logic [13:0] exp_outs();
    if (ext_mode_i) return {cfg_m[12:8], ofs_m[15:7]};
    return {3'b100, sw_pin, le_pin, 9'h000};
  endfunction
  task automatic cmp_outs();
    check({duty, phase, single, swing, edge_o, mag, neg}, exp_outs());
  endtask
  // frames of n bits; a pulse is expected only for 32 bits with the good header, and only address 1h or 2h land
  task automatic wr(input logic [11:0] h, input logic [3:0] a, input logic [15:0] d,
    input int n, input bit keep);
    i_host.send({h, a, d}, n, keep);
    if (n == 32 && h == FRAME_HEADER) begin
      n_exp++;
      if (a == 4'h1) cfg_m = d;
      else if (a == 4'h2) ofs_m = d;
    end
    if (!keep) begin
      repeat (8) @(posedge mclk_i);
      check(n_done, n_exp);
      cmp_outs();
    end
  endtask
  task automatic final_report();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(99191));
    repeat (8) @(posedge mclk_i);
    #10 resetn_i = 1'b1;
    repeat (5) @(posedge mclk_i);
    cmp_outs();
    $display("reset defaults done");
    for (int k = 0; k < 4; k++) begin
      #10 {ext_mode_i, le_pin, sw_pin} = {1'b0, 2'($urandom())};
      repeat (6) @(posedge mclk_i);
      cmp_outs();
    end
    #10 ext_mode_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    $display("normal mode pins done");
    for (int k = 0; k < 6; k++) wr(FRAME_HEADER, 4'h1, {3'b101, 5'($urandom()), 8'hFF}, 32, 0);
    for (int k = 0; k < 4; k++) wr(FRAME_HEADER, 4'h2, {9'($urandom()), 7'h7F}, 32, 0);
    $display("register writes done");
    wr(12'h002, 4'h1, 16'hA0FF, 32, 0);
    wr(12'h000, 4'h2, 16'h807F, 32, 0);
    foreach (bad_addr[i]) wr(FRAME_HEADER, bad_addr[i], 16'h0000, 32, 0);
    $display("refused frames done");
    wr(FRAME_HEADER, 4'h1, 16'hA0FF, 20, 0);
    wr(FRAME_HEADER, 4'h1, 16'hBFFF, 32, 1);
    wr(FRAME_HEADER, 4'h2, 16'hC1FF, 32, 0);
    $display("abort and back to back done");
    #10 ext_mode_i = 1'b0;
    repeat (6) @(posedge mclk_i);
    cmp_outs();
    #10 ext_mode_i = 1'b1;
    repeat (6) @(posedge mclk_i);
    cmp_outs();
    $display("mode return done");
    final_report();
  end
  // watchdog well beyond the expected half millisecond or so of traffic
  initial begin
    #(6_000_000);
    n_errors++;
    final_report();
  end
endmodule // tb
